/* File: spi_port_defines.svh */
// Register offsets, field positions and reset values of the serial port
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH
`define CTRL_ADDR   2'h0
`define STAT_ADDR   2'h1
`define DATA_ADDR   2'h2
`define IE_BIT      7
`define EN_BIT      6
`define ORD_BIT     5
`define ROLE_BIT    4
`define CLOCK_POLARITY_BIT_BIT    3
`define CLOCK_PHASE_BIT_BIT    2
`define DONE_BIT    7
`define WRITE_COLLISION_FLAG_BIT    6
`define DBL_BIT     0
`define CTRL_RST    8'h00
`define DATA_RST    8'h00
`define LAST_BIT    3'h7
`define LAST_EDGE   4'hf
`define SYNC_RST    4'hf
`endif

/* File: spi_port_pkg.sv */
// Types shared by the serial port design
package spi_port_pkg;
  typedef enum logic [1:0] {
    ROLE_OFF,
    ROLE_MASTER,
    ROLE_SLAVE_IDLE,
    ROLE_SLAVE_ACTIVE
  } port_role_t;
  typedef logic [1:0] reg_addr_t;
endpackage

/* File: spi_port.sv */
// Byte-wide serial port, master or slave, with control/status/data registers
//
// Function
// - Selected slave active; data-out drives if enabled
// - Deselected slave: all pins input, ignore data
// - Select high resets slave bit counter, shifter
// - Master with select output: select ignored
// - Master, select input low: drop to slave
// - That mode fault also sets done flag
// - Role bit stays cleared until software rewrites
// - Interrupt enable gates done flag onto request
// - Port enable required for any transfer
// - Bit order: one LSB first, zero MSB
// - Role bit one master, zero slave
// - Polarity sets clock idle level
// - Phase picks sampling on leading or trailing
// - Rate bits divide clock 4..128, ignored slave
// - Done flag cleared by vector or status-data
// - Data write mid-transfer sets collision flag
// - Status bits five to one read zero
// - Double-rate bit halves master divider
// - Data write starts; data read returns buffer
// - Drive and capture on opposite clock edges
// - Master shifts eight bits then stops clock
// - Transmit single, receive double buffered
// - Deselected slave keeps data-out off
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_defines.svh"

module spi_port (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       global_irq_en,
  input  wire logic       irq_ack,
  output var  logic       irq_req,
  input  wire logic       dir_sck,
  input  wire logic       dir_mosi,
  input  wire logic       dir_miso,
  input  wire logic       dir_ss,
  input  wire logic       ss_n_in,
  input  wire logic       sck_in,
  output var  logic       sck_out,
  output var  logic       sck_oe,
  input  wire logic       mosi_in,
  output var  logic       mosi_out,
  output var  logic       mosi_oe,
  input  wire logic       miso_in,
  output var  logic       miso_out,
  output var  logic       miso_oe
);

  // ==========================================================
  // Helpers
  function automatic logic [6:0] half_period(input logic dbl, input logic [1:0] rate);
    case ({dbl, rate})
      3'h0:    half_period = 7'h02;
      3'h1:    half_period = 7'h08;
      3'h2:    half_period = 7'h20;
      3'h3:    half_period = 7'h40;
      3'h4:    half_period = 7'h01;
      3'h5:    half_period = 7'h04;
      3'h6:    half_period = 7'h10;
      default: half_period = 7'h20;
    endcase
  endfunction

  function automatic logic head_bit(input logic [7:0] v, input logic lsb_first);
    head_bit = lsb_first ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic lsb_first);
    shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // ==========================================================
  // State
  logic [7:0] ctrl_reg;
  logic       done_reg;
  logic       write_collision_flag_reg;
  logic       dbl_reg;
  logic       clr_arm_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_buf_reg;
  logic       out_bit_reg;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       sck_prev_reg;
  logic       busy_reg;
  logic [6:0] div_cnt_reg;
  logic [3:0] edge_cnt_reg;
  logic       sck_reg;
  logic [2:0] bit_cnt_reg;
  logic       mid_byte_reg;

  logic       en, master, clock_polarity_bit, clock_phase_bit, lsb_first, ss_low, mode_fault;
  logic       slave_act, wr_data, rd_data, wr_ctrl, wr_stat, rd_stat;
  logic       data_acc, xfer_on, start, tick, m_lead, s_edge, s_lead;
  logic       edge_ev, lead, sample_ev, setup_ev, in_bit, done_ev, quiet;
  logic [6:0] half;
  spi_port_pkg::port_role_t role;

  // ==========================================================
  // Decode
  assign en        = ctrl_reg[`EN_BIT];
  assign master    = ctrl_reg[`ROLE_BIT];
  assign clock_polarity_bit      = ctrl_reg[`CLOCK_POLARITY_BIT_BIT];
  assign clock_phase_bit      = ctrl_reg[`CLOCK_PHASE_BIT_BIT];
  assign lsb_first = ctrl_reg[`ORD_BIT];
  assign ss_low    = !sync2_reg[3];
  assign mode_fault = en && master && !dir_ss && ss_low;
  assign slave_act = en && !master && ss_low;
  assign role = !en ? spi_port_pkg::ROLE_OFF :
                master ? spi_port_pkg::ROLE_MASTER :
                ss_low ? spi_port_pkg::ROLE_SLAVE_ACTIVE : spi_port_pkg::ROLE_SLAVE_IDLE;
  assign wr_data  = reg_wr && reg_addr == `DATA_ADDR;
  assign rd_data  = reg_rd && reg_addr == `DATA_ADDR;
  assign wr_ctrl  = reg_wr && reg_addr == `CTRL_ADDR;
  assign wr_stat  = reg_wr && reg_addr == `STAT_ADDR;
  assign rd_stat  = reg_rd && reg_addr == `STAT_ADDR;
  assign data_acc = wr_data || rd_data;
  assign xfer_on  = busy_reg || (slave_act && mid_byte_reg);
  assign start    = wr_data && en && master && !busy_reg && !mode_fault;
  assign half     = half_period(dbl_reg, ctrl_reg[1:0]);
  assign tick     = busy_reg && div_cnt_reg == half - 7'h01;
  assign m_lead   = !edge_cnt_reg[0];
  // Stage-two sample against its own delayed copy; fast clocks alias
  assign s_edge   = slave_act && sync2_reg[2] != sck_prev_reg;
  assign s_lead   = sync2_reg[2] != clock_polarity_bit;
  assign edge_ev  = master ? tick : s_edge;
  assign lead     = master ? m_lead : s_lead;
  assign sample_ev = edge_ev && (lead ^ clock_phase_bit);
  assign setup_ev  = edge_ev && !(lead ^ clock_phase_bit);
  assign in_bit   = master ? sync2_reg[0] : sync2_reg[1];
  assign done_ev  = sample_ev && bit_cnt_reg == `LAST_BIT;
  assign quiet    = !en || mode_fault || (!master && !ss_low);

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_reg    <= `SYNC_RST;
      sync2_reg    <= `SYNC_RST;
      // Matches the preset stage so no false edge follows reset
      sck_prev_reg <= 1'b1;
    end else if (clk_en) begin
      sync1_reg    <= {ss_n_in, sck_in, mosi_in, miso_in};
      sync2_reg    <= sync1_reg;
      sck_prev_reg <= sync2_reg[2];
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `CTRL_RST;
      dbl_reg  <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata;
      end
      // Fault overrides a same-cycle write to avoid bus contention
      if (mode_fault) begin
        ctrl_reg[`ROLE_BIT] <= 1'b0;
      end
      if (wr_stat) begin
        dbl_reg <= reg_wdata[`DBL_BIT];
      end
    end
  end

  // ==========================================================
  // Master clock generator
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_reg     <= 1'b0;
      div_cnt_reg  <= 7'h00;
      edge_cnt_reg <= 4'h0;
      sck_reg      <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        busy_reg     <= 1'b1;
        div_cnt_reg  <= 7'h00;
        edge_cnt_reg <= 4'h0;
        sck_reg      <= clock_polarity_bit;
      end else if (!busy_reg || mode_fault || !en) begin
        busy_reg <= 1'b0;
        sck_reg  <= clock_polarity_bit;
      end else if (tick) begin
        div_cnt_reg  <= 7'h00;
        sck_reg      <= !sck_reg;
        edge_cnt_reg <= edge_cnt_reg + 4'h1;
        if (edge_cnt_reg == `LAST_EDGE) begin
          busy_reg <= 1'b0;
        end
      end else begin
        div_cnt_reg <= div_cnt_reg + 7'h01;
      end
    end
  end

  // ==========================================================
  // Shift engine, shared by both roles
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shift_reg    <= `DATA_RST;
      tx_reg       <= `DATA_RST;
      rx_buf_reg   <= `DATA_RST;
      out_bit_reg  <= 1'b0;
      bit_cnt_reg  <= 3'h0;
      mid_byte_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_data && !xfer_on) begin
        // Only one transmit byte: a write mid-byte is dropped
        shift_reg   <= reg_wdata;
        tx_reg      <= reg_wdata;
        out_bit_reg <= head_bit(reg_wdata, lsb_first);
        if (quiet) begin
          // Select release in the same cycle still clears the count
          bit_cnt_reg  <= 3'h0;
          mid_byte_reg <= 1'b0;
        end
      end else if (quiet) begin
        bit_cnt_reg  <= 3'h0;
        mid_byte_reg <= 1'b0;
        if (mid_byte_reg) begin
          shift_reg   <= tx_reg;
          out_bit_reg <= head_bit(tx_reg, lsb_first);
        end
      end else if (sample_ev) begin
        shift_reg    <= shift_in(shift_reg, in_bit, lsb_first);
        bit_cnt_reg  <= bit_cnt_reg + 3'h1;
        mid_byte_reg <= !done_ev;
        if (done_ev) begin
          rx_buf_reg <= shift_in(shift_reg, in_bit, lsb_first);
        end
      end else if (setup_ev) begin
        out_bit_reg <= head_bit(shift_reg, lsb_first);
      end
    end
  end

  // ==========================================================
  // Status flags; a setting event wins over a clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_reg    <= 1'b0;
      write_collision_flag_reg    <= 1'b0;
      clr_arm_reg <= 1'b0;
    end else if (clk_en) begin
      if (done_ev || mode_fault) begin
        done_reg <= 1'b1;
      end else if (irq_ack || (clr_arm_reg && data_acc)) begin
        done_reg <= 1'b0;
      end
      if (wr_data && xfer_on) begin
        write_collision_flag_reg <= 1'b1;
      end else if (clr_arm_reg && data_acc) begin
        write_collision_flag_reg <= 1'b0;
      end
      if (rd_stat) begin
        clr_arm_reg <= done_reg || write_collision_flag_reg;
      end else if (data_acc) begin
        clr_arm_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read port and pin drivers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `CTRL_ADDR: reg_rdata <= ctrl_reg;
          `STAT_ADDR: reg_rdata <= {done_reg, write_collision_flag_reg, 5'h00, dbl_reg};
          `DATA_ADDR: reg_rdata <= rx_buf_reg;
          default:    reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sck_oe  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
      irq_req <= 1'b0;
    end else if (clk_en) begin
      sck_oe  <= role == spi_port_pkg::ROLE_MASTER && !mode_fault && dir_sck;
      mosi_oe <= role == spi_port_pkg::ROLE_MASTER && !mode_fault && dir_mosi;
      miso_oe <= role == spi_port_pkg::ROLE_SLAVE_ACTIVE && dir_miso;
      irq_req <= done_reg && ctrl_reg[`IE_BIT] && global_irq_en;
    end
  end

  assign sck_out  = sck_reg;
  assign mosi_out = out_bit_reg;
  assign miso_out = out_bit_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence stat_read_flagged;
    clk_en && rd_stat && (done_reg || write_collision_flag_reg);
  endsequence
  sequence data_access_quiet;
    clk_en && data_acc && !rd_stat && !done_ev && !mode_fault && !(wr_data && xfer_on);
  endsequence
  sequence bus_gap;
    clk_en && !reg_rd && !reg_wr && !irq_ack;
  endsequence

  mode_fault_role_a: assert property (clk_en && mode_fault |=> !master && done_reg)
    else $error("mode fault did not drop role");
  fault_pins_off_a: assert property (clk_en && mode_fault |=> !sck_oe && !mosi_oe)
    else $error("master pins still driven after fault");
  role_held_a: assert property (clk_en && !master && !wr_ctrl |=> !master)
    else $error("role bit set by hardware");
  slave_reset_a: assert property (clk_en && en && !master && !ss_low |=> bit_cnt_reg == 3'h0)
    else $error("slave counter not reset by select");
  slave_idle_a: assert property (clk_en && !master && !ss_low |=> !miso_oe)
    else $error("deselected slave drives data-out");
  stat_res_a: assert property (clk_en && rd_stat |=> reg_rdata[5:1] == 5'h00)
    else $error("reserved status bits not zero");
  start_busy_a: assert property (clk_en && start |=> busy_reg && edge_cnt_reg == 4'h0)
    else $error("data write did not start master");
  write_collision_flag_set_a: assert property (clk_en && wr_data && xfer_on |=> write_collision_flag_reg)
    else $error("collision not flagged");
  flag_clear_a: assert property (stat_read_flagged ##1 data_access_quiet |=> !done_reg && !write_collision_flag_reg)
    else $error("status-data sequence did not clear flags");
  irq_gate_a: assert property (clk_en && done_reg && ctrl_reg[`IE_BIT] && global_irq_en |=> irq_req)
    else $error("interrupt request missing");
  rx_hold_a: assert property (clk_en && !done_ev |=> $stable(rx_buf_reg))
    else $error("receive buffer changed mid-byte");
  disabled_idle_a: assert property (clk_en && !en |=> !busy_reg)
    else $error("transfer while disabled");
  flag_clear_gap_a: assert property (stat_read_flagged ##1 bus_gap ##1 data_access_quiet |=> !done_reg && !write_collision_flag_reg)
    else $error("spaced status-data sequence did not clear flags");
  irq_clear_a: assert property (clk_en && irq_ack && !done_ev && !mode_fault |=> !done_reg)
    else $error("vector did not clear done flag");
  done_set_a: assert property (clk_en && done_ev |=> done_reg)
    else $error("done flag not set after last bit");
  miso_sel_a: assert property (clk_en && role == spi_port_pkg::ROLE_SLAVE_ACTIVE && dir_miso |=> miso_oe)
    else $error("selected slave does not drive data-out");
  sck_idle_a: assert property (clk_en && !busy_reg && !start |=> sck_out == $past(clock_polarity_bit))
    else $error("clock not idle at polarity");
  ss_output_a: assert property (clk_en && en && master && dir_ss && !wr_ctrl |=> master)
    else $error("select output disturbed master role");
  master_stop_a: assert property (clk_en && tick && edge_cnt_reg == `LAST_EDGE && en && !mode_fault |=> !busy_reg)
    else $error("master clock did not stop after byte");
  slave_quiet_a: assert property (clk_en && en && !master && !ss_low |=> !mid_byte_reg)
    else $error("deselected slave kept partial byte");

endmodule // spi_port

`default_nettype wire

/* File: spi_far_model.sv */
// Far-side serial slave answering the port in any of the four modes
`timescale 1ns/1ps
`default_nettype none

module spi_far_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       clock_polarity_bit,
  input  wire logic       clock_phase_bit,
  input  wire logic       lsb,
  input  wire logic [7:0] tx_byte,
  output var  logic       miso,
  output var  logic [7:0] rx_byte
);
  logic [7:0] sh;
  int         n;

  initial begin
    miso = 1'b1;
    rx_byte = 8'h00;
  end
  // ==========
  // Shifting
  always @(negedge ss_n) begin
    sh = tx_byte;
    n = 0;
    miso = lsb ? sh[0] : sh[7];
  end
  // No pull on the line, so a released bit flips instead of holding
  always @(posedge ss_n) miso = ~miso;
  always @(sck) begin
    if (!ss_n && (((sck != clock_polarity_bit) ^ clock_phase_bit) == 1'b1)) begin
      rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      n = n + 1;
    end else if (!ss_n && n < 8) begin
      miso = lsb ? sh[n] : sh[7 - n];
    end
  end
endmodule  // spi_far_model

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the serial port registers and pins
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       gie = 1'b0;
  logic       irq_ack = 1'b0;
  logic       irq_req;
  logic       dir_sck = 1'b1;
  logic       dir_mosi = 1'b1;
  logic       dir_miso = 1'b0;
  logic       dir_ss = 1'b1;
  logic       ss_line = 1'b1;
  logic       tb_sck = 1'b0;
  logic       tb_mosi = 1'b0;
  logic       sck_out;
  logic       sck_oe;
  logic       mosi_out;
  logic       mosi_oe;
  logic       miso_out;
  logic       miso_oe;
  logic       far_miso;
  logic       clock_polarity_bit = 1'b0;
  logic       clock_phase_bit = 1'b0;
  logic       lsb = 1'b0;
  logic [7:0] far_tx = 8'h00;
  logic [7:0] far_rx;
  int         num_errors = 0;
  int         n_tests = 0;
  wire logic  sck_w = sck_oe ? sck_out : tb_sck;
  wire logic  mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire logic  miso_w = miso_oe ? miso_out : far_miso;

  always #5 clk_sys = ~clk_sys;

  spi_port u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_irq_en(gie), .irq_ack(irq_ack), .irq_req(irq_req), .dir_sck(dir_sck),
    .dir_mosi(dir_mosi), .dir_miso(dir_miso), .dir_ss(dir_ss), .ss_n_in(ss_line),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe)
  );

  spi_far_model u_far (
    .sck(sck_w), .mosi(mosi_w), .ss_n(ss_line), .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit), .lsb(lsb),
    .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx)
  );

  // ==========
  // Bus and compare helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [1:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask
  task automatic wait_done(output logic [7:0] s);
    s = 8'h00;
    for (int k = 0; k < 1000 && s[7] !== 1'b1; k++) rd(2'h1, s);
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset;
    rc(2'h0, 8'h00, "control");
    rc(2'h1, 8'h00, "status");
    rc(2'h2, 8'h00, "data");
    wr(2'h3, 8'hff);
    rc(2'h3, 8'h00, "unmapped");
    wr(2'h1, 8'hff);
    rc(2'h1, 8'h01, "status reserved");
    wr(2'h1, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_modes;
    logic [7:0] tx;
    logic [7:0] s;
    for (int m = 0; m < 4; m++) begin
      tx = 8'h96 + 8'(m);
      far_tx <= 8'h3b + 8'(m * 16);
      {clock_polarity_bit, clock_phase_bit} <= 2'(m);
      lsb <= m[0];
      wr(2'h0, {2'h1, 1'(m), 1'h1, 2'(m), 2'h1});
      edges(3);
      #1 chk("idle clock", {7'h00, clock_polarity_bit}, {7'h00, sck_out});
      @(posedge clk_sys);
      ss_line <= 1'b0;
      wr(2'h2, tx);
      wait_done(s);
      rc(2'h2, far_tx, "rx byte");
      chk("far rx", tx, far_rx);
      rc(2'h1, 8'h00, "flag cleared");
      edges(16);
      ss_line <= 1'b1;
    end
    $display("mode test done");
  endtask
  task automatic t_rates;
    logic [7:0] hp [8] = '{8'h02, 8'h08, 8'h20, 8'h40, 8'h01, 8'h04, 8'h10, 8'h20};
    logic [7:0] s;
    int         k;
    for (int r = 0; r < 8; r++) begin
      wr(2'h1, {7'h00, 1'(r >> 2)});
      wr(2'h0, {6'h14, 2'(r)});
      wr(2'h2, 8'h55);
      #1;
      for (k = 0; k < 200 && sck_out !== 1'b1; k++) #10;
      for (k = 0; k < 200 && sck_out === 1'b1; k++) #10;
      chk("half period", hp[r], 8'(k));
      wait_done(s);
      rd(2'h2, s);
      edges(70);
    end
    wr(2'h1, 8'h00);
    $display("rate test done");
  endtask
  task automatic t_collide;
    logic [7:0] s;
    wr(2'h0, 8'h51);
    wr(2'h2, 8'ha5);
    wr(2'h2, 8'h5a);
    wait_done(s);
    chk("collision", 8'hc0, s);
    rd(2'h2, s);
    rc(2'h1, 8'h00, "both cleared");
    edges(20);
    wr(2'h0, 8'h11);
    wr(2'h2, 8'hff);
    edges(60);
    rc(2'h1, 8'h00, "disabled idle");
    $display("collision test done");
  endtask
  task automatic t_fault;
    wr(2'h0, 8'hd1);
    gie <= 1'b1;
    dir_ss <= 1'b0;  // ss_line still high
    edges(4);
    ss_line <= 1'b0;
    edges(6);
    #1 chk("irq", 8'h01, {7'h00, irq_req});
    chk("clock oe", 8'h00, {7'h00, sck_oe});
    chk("data oe", 8'h00, {7'h00, mosi_oe});
    rc(2'h0, 8'hc1, "role cleared");
    @(posedge clk_sys);
    ss_line <= 1'b1;
    edges(6);
    rc(2'h0, 8'hc1, "role stays");
    @(posedge clk_sys);
    irq_ack <= 1'b1;
    @(posedge clk_sys);
    irq_ack <= 1'b0;
    edges(2);
    #1 chk("irq ack", 8'h00, {7'h00, irq_req});
    @(posedge clk_sys);
    gie <= 1'b0;
    dir_ss <= 1'b1;
    $display("fault test done");
  endtask
  task automatic sl_bits(input logic [7:0] b, input int n, output logic [7:0] got);
    // Twelve-cycle bit period keeps the external clock under a quarter rate
    for (int i = 0; i < n; i++) begin
      tb_mosi <= b[7 - i];
      edges(6);
      got[7 - i] = miso_w;
      tb_sck <= 1'b1;
      edges(6);
      tb_sck <= 1'b0;
    end
  endtask
  task automatic t_slave;
    logic [7:0] got;
    dir_sck <= 1'b0;
    dir_mosi <= 1'b0;
    dir_miso <= 1'b1;
    wr(2'h0, 8'h40);
    wr(2'h2, 8'h3c);
    #1 chk("oe deselected", 8'h00, {7'h00, miso_oe});
    @(posedge clk_sys);
    ss_line <= 1'b0;
    edges(8);
    #1 chk("oe selected", 8'h01, {7'h00, miso_oe});
    sl_bits(8'hff, 3, got);
    ss_line <= 1'b1;
    edges(8);
    ss_line <= 1'b0;
    edges(8);
    sl_bits(8'h5a, 8, got);
    edges(8);
    chk("slave tx", 8'h3c, got);
    rc(2'h1, 8'h80, "slave done");
    rc(2'h2, 8'h5a, "slave rx");
    ss_line <= 1'b1;
    $display("slave test done");
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    edges(2);
    rstn <= 1'b1;
    t_reset();
    t_modes();
    t_rates();
    t_collide();
    t_fault();
    t_slave();
    print_verdict();
  end
  // Whole run is under 5k cycles; this cuts a hang well after that
  initial begin
    #1_000_000;
    num_errors++;
    print_verdict();
  end
endmodule  // tb_top

`default_nettype wire
